// ### rtl/timing_bank_pkg.sv
// Purpose: shared constants for the timing core register bank and its host
// Assumes: 9-bit byte address space, 8-bit registers
// Notes: bit masks mark the writable or latched bits of each register
package timing_bank_pkg;

	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam logic [1:0] REGION_CORE = 2'h0;

	// Core register offsets
	localparam logic [6:0] OFS_IDENT_LOW = 7'h00;
	localparam logic [6:0] OFS_IDENT_HIGH = 7'h01;
	localparam logic [6:0] OFS_REVISION = 7'h02;
	localparam logic [6:0] OFS_INPUT_ACT_LATCH = 7'h05;
	localparam logic [6:0] OFS_FREQ_TOP = 7'h07;
	localparam logic [6:0] OFS_LOOP_LINE_LATCH = 7'h08;
	localparam logic [6:0] OFS_LOOP_STATE = 7'h09;
	localparam logic [6:0] OFS_PRIO_TABLE_A = 7'h0A;
	localparam logic [6:0] OFS_PRIO_TABLE_B = 7'h0B;
	localparam logic [6:0] OFS_FREQ_LOW = 7'h0C;
	localparam logic [6:0] OFS_FREQ_MID = 7'h0D;
	localparam logic [6:0] OFS_VALID_STATE = 7'h0E;
	localparam logic [6:0] OFS_STATUS_PAIR_A = 7'h10;
	localparam logic [6:0] OFS_STATUS_PAIR_B = 7'h11;
	localparam logic [6:0] OFS_ABORT_SYNC_LATCH = 7'h17;
	localparam logic [6:0] OFS_SOFT_RESET = 7'h32;
	localparam logic [6:0] OFS_STRAP_STATE = 7'h37;
	localparam logic [6:0] OFS_MCLK_LOW = 7'h3C;
	localparam logic [6:0] OFS_MCLK_HIGH = 7'h3D;
	localparam logic [6:0] OFS_INPUT_ACT_IRQ_EN = 7'h43;
	localparam logic [6:0] OFS_LOOP_LINE_IRQ_EN = 7'h45;
	localparam logic [6:0] OFS_DIVIDER_LOW = 7'h46;
	localparam logic [6:0] OFS_DIVIDER_HIGH = 7'h47;
	localparam logic [6:0] OFS_FREQ_RESULT = 7'h4C;
	localparam logic [6:0] OFS_SYNC_IRQ_EN = 7'h4E;
	localparam logic [6:0] OFS_PHASE_LOW = 7'h77;
	localparam logic [6:0] OFS_PHASE_HIGH = 7'h78;

	// Bit layout
	localparam int SOFT_RESET_BIT = 7;
	localparam int ABORT_FLAG_BIT = 5;
	localparam logic [7:0] MASK_INPUT_ACT = 8'h0F;
	localparam logic [7:0] MASK_LOOP_LINE = 8'h5F;
	localparam logic [7:0] MASK_ABORT_SYNC = 8'h2F;
	localparam logic [7:0] MASK_IRQ_EN_SYNC = 8'h0F;

	// Transition that sets each latched bit
	localparam logic [7:0] RISE_INPUT_ACT = 8'h0F;
	localparam logic [7:0] FALL_INPUT_ACT = 8'h0F;
	localparam logic [7:0] RISE_LOOP_LINE = 8'h5F;
	localparam logic [7:0] FALL_LOOP_LINE = 8'h40;
	localparam logic [7:0] RISE_ABORT_SYNC = 8'h0F;
	localparam logic [7:0] FALL_ABORT_SYNC = 8'h00;

	// Multi-byte field codes
	localparam logic [1:0] FID_FREQ = 2'h0;
	localparam logic [1:0] FID_MCLK = 2'h1;
	localparam logic [1:0] FID_DIVIDER = 2'h2;
	localparam logic [1:0] FID_PHASE = 2'h3;
	localparam logic [2:0] BYTES_THREE = 3'h7;
	localparam logic [2:0] BYTES_TWO = 3'h3;

	typedef struct packed {
		logic hit;
		logic [1:0] fid;
		logic [1:0] idx;
	} mb_slot_t;

	// Host controller register offsets
	localparam logic [3:0] HOFS_COMMAND = 4'h0;
	localparam logic [3:0] HOFS_STATUS = 4'h4;
	localparam int CMD_WRITE_BIT = 31;
	localparam int CMD_DATA_LSB = 16;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// Writable bits of the plain configuration registers; zero elsewhere
	function automatic logic [7:0] rw_mask(input logic [6:0] a);
		case (a)
			7'h03: rw_mask = 8'h04;
			7'h18, 7'h19, 7'h20, 7'h21, 7'h22, 7'h23: rw_mask = 8'hFF;
			7'h30: rw_mask = 8'h0F;
			7'h34: rw_mask = 8'h26;
			7'h36: rw_mask = 8'hF0;
			7'h43: rw_mask = 8'h0F;
			7'h45: rw_mask = 8'h5F;
			7'h48: rw_mask = 8'h83;
			7'h49, 7'h4D: rw_mask = 8'hFF;
			7'h4B: rw_mask = 8'h1F;
			7'h4E: rw_mask = 8'h0F;
			7'h50, 7'h51, 7'h52, 7'h54, 7'h55, 7'h56, 7'h58: rw_mask = 8'hFF;
			7'h53, 7'h57: rw_mask = 8'h03;
			default: rw_mask = 8'h00;
		endcase
	endfunction : rw_mask

	function automatic mb_slot_t mb_lookup(input logic [6:0] a);
		case (a)
			OFS_FREQ_LOW: mb_lookup = '{1'b1, FID_FREQ, 2'h0};
			OFS_FREQ_MID: mb_lookup = '{1'b1, FID_FREQ, 2'h1};
			OFS_FREQ_TOP: mb_lookup = '{1'b1, FID_FREQ, 2'h2};
			OFS_MCLK_LOW: mb_lookup = '{1'b1, FID_MCLK, 2'h0};
			OFS_MCLK_HIGH: mb_lookup = '{1'b1, FID_MCLK, 2'h1};
			OFS_DIVIDER_LOW: mb_lookup = '{1'b1, FID_DIVIDER, 2'h0};
			OFS_DIVIDER_HIGH: mb_lookup = '{1'b1, FID_DIVIDER, 2'h1};
			OFS_PHASE_LOW: mb_lookup = '{1'b1, FID_PHASE, 2'h0};
			OFS_PHASE_HIGH: mb_lookup = '{1'b1, FID_PHASE, 2'h1};
			default: mb_lookup = '{1'b0, 2'h0, 2'h0};
		endcase
	endfunction : mb_lookup

endpackage : timing_bank_pkg

// ### rtl/host_bus_if.sv
// Purpose: byte-wide host port between controller and register bank
// Assumes: one clock shared by both ends
// Notes: request stands until the one-cycle acknowledge
`timescale 1ns/1ps
interface host_bus_if;
	logic req;
	logic wr;
	logic [8:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	logic irq_request_output;

	modport dev (
		input req,
		input wr,
		input addr,
		input wdata,
		output rdata,
		output ack,
		output irq_request_output
	);

	modport ctl (
		output req,
		output wr,
		output addr,
		output wdata,
		input rdata,
		input ack,
		input irq_request_output
	);
endinterface : host_bus_if

// ### rtl/timing_reg_bank.sv
// Purpose: host register bank of the timing core
// Assumes: monitor inputs come from logic on clk; straps come from pins
// Notes: transceiver and reserved regions take writes and read as zero
//
// Contract
// [R1] Decode four 128-byte regions, reserved accepts writes
// [R2] Host may access every address up to top
// [R3] Registers eight bits, bit seven most significant
// [R4] Host writes zero to reserved bits, addresses
// [R5] Host writes fixed bits with their value
// [R6] Read-only fields ignore writes; others read-write
// [R7] Real-time status returns current signal level
// [R8] Latched bit sets on configured transition
// [R9] Latched bit clears only on writing one
// [R10] Interrupt request when enabled latched bit set
// [R11] Reset returns configuration to defaults
// [R12] Multi-byte write commits after all bytes, uninterrupted
// [R13] Interrupted write discards bytes, sets abort flag
// [R14] Reading one byte freezes the remaining bytes
// [R15] Interrupted read unfreezes, sets abort flag
// [R16] Four multi-byte fields at listed addresses
// [R17] Host masks its interrupts during multi-byte access
// [R18] Soft reset spares port, itself; keeps straps
// [R19] Host waits 100 us after any reset
// [R20] Reserved reads return zero, change nothing
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module timing_reg_bank #(
	parameter logic [15:0] IDENT_CODE = 16'h5A3C, // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value
) (
	input wire logic clk,
	input wire logic nrst,
	host_bus_if.dev bus,
	input wire logic [3:0] input_activity,
	input wire logic [7:0] loop_line_events,
	input wire logic [3:0] sync_presence,
	input wire logic [3:0] input_valid_level,
	input wire logic [7:0] loop_state_level,
	input wire logic [15:0] priority_table_level,
	input wire logic [15:0] input_status_level,
	input wire logic [7:0] freq_result_level,
	input wire logic [18:0] measured_frequency_field,
	input wire logic [15:0] phase_level,
	input wire logic [2:0] strap_pins,
	output logic [15:0] master_clock_adjust_field,
	output logic [14:0] divider_ratio_field,
	output logic soft_reset
);
	import timing_bank_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic ack_q;
	logic [7:0] rdata_q;
	logic [7:0] cfg_q [0:127];
	logic soft_q;
	logic [2:0] strap_s1_q, strap_s2_q, strap_q;
	logic strap_taken_q;
	logic [7:0] act_lat_q, line_lat_q, sync_lat_q;
	logic [3:0] act_prev_q, sync_prev_q;
	logic [7:0] line_prev_q;
	logic [15:0] mclk_q;
	logic [14:0] divn_q;
	logic mb_act_q, mb_rd_q;
	logic [1:0] mb_fid_q;
	logic [2:0] mb_done_q;
	logic [23:0] stage_q;

	logic take, wr_take, rd_take, core, hold;
	logic [6:0] ofs;
	logic [7:0] wsel;
	mb_slot_t slot;
	logic mb_hit, mb_cont, mb_abort, mb_last;
	logic [2:0] full, done_d;
	logic [23:0] live, merged;
	logic [7:0] rd_d;

	function automatic logic [7:0] latch_next(input logic [7:0] cur,
			input logic [7:0] sig, input logic [7:0] prev,
			input logic [7:0] rise, input logic [7:0] fall,
			input logic [7:0] clr);
		// Set wins over a clear in the same cycle
		latch_next = (cur & ~clr) | (sig & ~prev & rise) | (~sig & prev & fall);
	endfunction : latch_next

	function automatic logic [7:0] pick(input logic [23:0] v,
			input logic [1:0] i);
		case (i)
			2'h0: pick = v[7:0];
			2'h1: pick = v[15:8];
			default: pick = v[23:16];
		endcase
	endfunction : pick

	////////////////////////////////////////////////////////////////////////
	// Access decode
	assign take = bus.req & ~ack_q;
	assign wr_take = take & bus.wr;
	assign rd_take = take & ~bus.wr;
	assign core = bus.addr[8:7] == REGION_CORE; // R1
	assign ofs = bus.addr[6:0];
	assign wsel = bus.wdata & {8{wr_take & core}};
	assign hold = ~nrst | soft_q; // R18

	assign slot = mb_lookup(ofs);
	assign mb_hit = core & slot.hit; // R16
	assign full = (slot.fid == FID_FREQ) ? BYTES_THREE : BYTES_TWO;
	assign mb_cont = mb_act_q & mb_hit & (slot.fid == mb_fid_q)
		& (mb_rd_q == ~bus.wr) & ~mb_done_q[slot.idx];
	assign mb_abort = take & mb_act_q & ~mb_cont; // R13 R15
	assign done_d = (mb_cont ? mb_done_q : 3'h0) | (3'h1 << slot.idx);
	assign mb_last = done_d == full;

	always_comb begin
		case (slot.fid)
			FID_FREQ: live = {5'h00, measured_frequency_field};
			FID_MCLK: live = {8'h00, mclk_q};
			FID_DIVIDER: live = {9'h000, divn_q};
			default: live = {8'h00, phase_level};
		endcase
		merged = mb_cont ? stage_q : live;
		case (slot.idx)
			2'h0: merged[7:0] = bus.wdata;
			2'h1: merged[15:8] = bus.wdata;
			default: merged[23:16] = bus.wdata;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer
	always_comb begin
		rd_d = 8'h00; // R20
		if (core) begin
			case (ofs)
				OFS_IDENT_LOW: rd_d = IDENT_CODE[7:0];
				OFS_IDENT_HIGH: rd_d = IDENT_CODE[15:8];
				OFS_REVISION: rd_d = REVISION_CODE;
				OFS_INPUT_ACT_LATCH: rd_d = act_lat_q;
				OFS_LOOP_LINE_LATCH: rd_d = line_lat_q;
				OFS_ABORT_SYNC_LATCH: rd_d = sync_lat_q;
				OFS_LOOP_STATE: rd_d = loop_state_level & 8'h58; // R7
				OFS_PRIO_TABLE_A: rd_d = priority_table_level[7:0];
				OFS_PRIO_TABLE_B: rd_d = priority_table_level[15:8];
				OFS_VALID_STATE: rd_d = {4'h0, input_valid_level}; // R7
				OFS_STATUS_PAIR_A: rd_d = input_status_level[7:0] & 8'hEE;
				OFS_STATUS_PAIR_B: rd_d = input_status_level[15:8] & 8'hEE;
				OFS_SOFT_RESET: rd_d = {soft_q, 7'h00};
				OFS_STRAP_STATE: rd_d = {5'h00, strap_q};
				OFS_FREQ_RESULT: rd_d = freq_result_level;
				default: rd_d = cfg_q[ofs] & rw_mask(ofs);
			endcase
			if (mb_hit) begin
				rd_d = mb_cont ? pick(stage_q, slot.idx)
					: pick(live, slot.idx); // R14
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host port answer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= take;
			if (rd_take) begin
				rdata_q <= rd_d;
			end
		end
	end

	assign bus.ack = ack_q;
	assign bus.rdata = rdata_q; // R3

	////////////////////////////////////////////////////////////////////////
	// Soft reset bit and straps survive a soft reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			soft_q <= 1'b0;
		end else if (wr_take && core && ofs == OFS_SOFT_RESET) begin
			soft_q <= bus.wdata[SOFT_RESET_BIT]; // R18
		end
	end

	always_ff @(posedge clk) begin
		strap_s1_q <= strap_pins;
		strap_s2_q <= strap_s1_q;
	end

	// Caught once after hardware reset release only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			strap_taken_q <= 1'b0;
			strap_q <= 3'h0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			strap_q <= strap_s2_q; // R18
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain configuration registers, reserved bits never stored
	always_ff @(posedge clk) begin
		if (hold) begin
			for (int i = 0; i < 128; i++) begin
				cfg_q[i] <= 8'h00; // R11
			end
		end else if (wr_take && core && !mb_hit) begin
			cfg_q[ofs] <= bus.wdata & rw_mask(ofs); // R6
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latched status
	always_ff @(posedge clk) begin
		if (hold) begin
			act_lat_q <= 8'h00;
			line_lat_q <= 8'h00;
			sync_lat_q <= 8'h00;
			act_prev_q <= 4'h0;
			line_prev_q <= 8'h00;
			sync_prev_q <= 4'h0;
		end else begin
			act_prev_q <= input_activity;
			line_prev_q <= loop_line_events;
			sync_prev_q <= sync_presence;
			act_lat_q <= latch_next(act_lat_q, {4'h0, input_activity},
				{4'h0, act_prev_q}, RISE_INPUT_ACT, FALL_INPUT_ACT,
				(ofs == OFS_INPUT_ACT_LATCH) ? wsel : 8'h00) // R8 R9
				& MASK_INPUT_ACT;
			line_lat_q <= latch_next(line_lat_q, loop_line_events,
				line_prev_q, RISE_LOOP_LINE, FALL_LOOP_LINE,
				(ofs == OFS_LOOP_LINE_LATCH) ? wsel : 8'h00) // R8 R9
				& MASK_LOOP_LINE;
			sync_lat_q <= (latch_next(sync_lat_q, {4'h0, sync_presence},
				{4'h0, sync_prev_q}, RISE_ABORT_SYNC, FALL_ABORT_SYNC,
				(ofs == OFS_ABORT_SYNC_LATCH) ? wsel : 8'h00) // R9
				| {2'h0, mb_abort, 5'h00}) & MASK_ABORT_SYNC; // R13 R15
		end
	end

	assign bus.irq_request_output =
		|(act_lat_q & cfg_q[OFS_INPUT_ACT_IRQ_EN])
		| |(line_lat_q & cfg_q[OFS_LOOP_LINE_IRQ_EN])
		| |(sync_lat_q & cfg_q[OFS_SYNC_IRQ_EN] & MASK_IRQ_EN_SYNC); // R10

	////////////////////////////////////////////////////////////////////////
	// Multi-byte sequencing
	always_ff @(posedge clk) begin
		if (hold) begin
			mb_act_q <= 1'b0;
			mb_rd_q <= 1'b0;
			mb_fid_q <= 2'h0;
			mb_done_q <= 3'h0;
			stage_q <= 24'h000000;
		end else if (take) begin
			if (mb_hit) begin
				mb_act_q <= ~mb_last; // R12
				mb_rd_q <= ~bus.wr;
				mb_fid_q <= slot.fid;
				mb_done_q <= mb_last ? 3'h0 : done_d;
				if (bus.wr) begin
					stage_q <= merged;
				end else if (!mb_cont) begin
					stage_q <= live; // R14
				end
			end else begin
				mb_act_q <= 1'b0; // R13 R15
				mb_done_q <= 3'h0;
			end
		end
	end

	// Field commits only on the final byte of an unbroken write
	always_ff @(posedge clk) begin
		if (hold) begin
			mclk_q <= 16'h0000;
			divn_q <= 15'h0000;
		end else if (wr_take && mb_hit && mb_last) begin
			if (slot.fid == FID_MCLK) begin
				mclk_q <= merged[15:0]; // R12
			end
			if (slot.fid == FID_DIVIDER) begin
				divn_q <= merged[14:0]; // R12
			end
		end
	end

	assign master_clock_adjust_field = mclk_q;
	assign divider_ratio_field = divn_q;
	assign soft_reset = soft_q;

endmodule : timing_reg_bank

// ### rtl/timing_host_ctl.sv
// Purpose: AXI4-Lite controller that runs single host port accesses
// Assumes: software issues one byte access at a time
// Notes: a command written while busy is refused with SLVERR
`timescale 1ns/1ps
module timing_host_ctl (
	input wire logic clk,
	input wire logic nrst,
	host_bus_if.ctl bus,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq_level
);
	import timing_bank_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic req_q, wr_q, busy_q;
	logic [8:0] addr_q;
	logic [7:0] wdata_q, last_q;
	logic [1:0] bresp_q, rresp_q;
	logic bvalid_q, rvalid_q;
	logic [31:0] rdata_q;
	logic wtake, rtake, cmd_ok;

	// Both channels taken together keeps the slave free of holding state
	assign wtake = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
	assign rtake = s_axi_arvalid & ~rvalid_q;
	assign s_axi_awready = wtake;
	assign s_axi_wready = wtake;
	assign s_axi_arready = rtake;
	assign cmd_ok = s_axi_awaddr[3:0] == HOFS_COMMAND && !busy_q
		&& s_axi_wstrb == 4'hF;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= AXI_OKAY;
		end else if (wtake) begin
			bvalid_q <= 1'b1;
			bresp_q <= cmd_ok ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rresp_q <= AXI_OKAY;
			rdata_q <= 32'h00000000;
		end else if (rtake) begin
			rvalid_q <= 1'b1;
			rresp_q <= (s_axi_araddr[3:0] == HOFS_STATUS) ? AXI_OKAY
				: AXI_SLVERR;
			rdata_q <= (s_axi_araddr[3:0] == HOFS_STATUS)
				? {16'h0000, last_q, 6'h00, bus.irq_request_output, busy_q}
				: 32'h00000000;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host port: one access at a time, request held until acknowledge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			req_q <= 1'b0;
			busy_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 9'h000;
			wdata_q <= 8'h00;
			last_q <= 8'h00;
		end else if (busy_q) begin
			if (bus.ack) begin
				req_q <= 1'b0;
				busy_q <= 1'b0;
				if (!wr_q) begin
					last_q <= bus.rdata;
				end
			end
		end else if (wtake && cmd_ok) begin
			req_q <= 1'b1; // R2
			busy_q <= 1'b1;
			wr_q <= s_axi_wdata[CMD_WRITE_BIT];
			addr_q <= s_axi_wdata[8:0];
			wdata_q <= s_axi_wdata[CMD_DATA_LSB +: 8]; // R4 R5
		end
	end

	assign bus.req = req_q;
	assign bus.wr = wr_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign irq_level = bus.irq_request_output;

endmodule : timing_host_ctl

// ### tb/timing_bank_props.sv
// Purpose: host port checks between controller and register bank
// Assumes: one clock, nrst synchronous active low
// Notes: sees only the interface signals
`timescale 1ns/1ps
module timing_bank_props #(
	parameter logic [15:0] IDENT_CODE = 16'h5A3C, // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire logic wr,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic irq_request_output
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	property p_ack_next;
		req && !ack |=> ack;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("no acknowledge after request");
	property p_ack_pulse;
		ack |=> !ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("acknowledge longer than one cycle");
	property p_ack_cause;
		$rose(ack) |-> $past(req);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("acknowledge without request");
	property p_region_zero;
		ack && !wr && addr[8:7] != 2'h0 |-> rdata == 8'h00;
	endproperty
	a_region_zero: assert property (p_region_zero)
		else $error("non-core region read not zero");
	property p_unlisted_zero;
		ack && !wr && addr == 9'h004 |-> rdata == 8'h00;
	endproperty
	a_unlisted_zero: assert property (p_unlisted_zero)
		else $error("unlisted address read not zero");
	property p_ident;
		ack && !wr && addr == 9'h000 |-> rdata == IDENT_CODE[7:0];
	endproperty
	a_ident: assert property (p_ident)
		else $error("identity byte changed");
	property p_revision;
		ack && !wr && addr == 9'h002 |-> rdata == REVISION_CODE;
	endproperty
	a_revision: assert property (p_revision)
		else $error("revision byte wrong");
	property p_freq_top;
		ack && !wr && addr == 9'h007 |-> rdata[7:3] == 5'h00;
	endproperty
	a_freq_top: assert property (p_freq_top)
		else $error("frequency top byte reserved bits set");
	property p_write_keeps;
		ack && wr |-> $stable(rdata);
	endproperty
	a_write_keeps: assert property (p_write_keeps)
		else $error("write changed read data");
endmodule : timing_bank_props

// ### tb/tb_top.sv
// Purpose: controller and register bank run end to end over AXI4-Lite
// Assumes: one clock at 100 MHz
// Notes: field and monitor inputs are driven directly by the bench
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] ident_val = 16'hA55A; // Arbitrary value
	localparam logic [7:0] rev_val = 8'h07; // Arbitrary value
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq_level, soft_reset;
	logic [1:0] bresp, rresp;
	logic [3:0] act = '0, sync = '0, valid_lvl = '0;
	logic [7:0] loop_ev = '0, loop_st = 8'h58, fres = 8'h3C;
	logic [15:0] ptab = 16'h1234, istat = 16'hEEEE, phase = '0, mclk;
	logic [18:0] meas = '0;
	logic [2:0] straps = 3'h5;
	logic [14:0] divn;
	logic [8:0] far [4] = '{9'h080, 9'h100, 9'h180, 9'h1FF};
	int mismatches = 0, comparisons = 0;
	host_bus_if hb();
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	timing_reg_bank #(.IDENT_CODE(ident_val), .REVISION_CODE(rev_val))
	timing_reg_bank_inst (.clk(clk), .nrst(nrst), .bus(hb),
		.input_activity(act), .loop_line_events(loop_ev),
		.sync_presence(sync), .input_valid_level(valid_lvl),
		.loop_state_level(loop_st), .priority_table_level(ptab),
		.input_status_level(istat), .freq_result_level(fres),
		.measured_frequency_field(meas), .phase_level(phase),
		.strap_pins(straps), .master_clock_adjust_field(mclk),
		.divider_ratio_field(divn), .soft_reset(soft_reset));
	timing_host_ctl timing_host_ctl_inst (.clk(clk), .nrst(nrst), .bus(hb),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_level(irq_level));
	timing_bank_props #(.IDENT_CODE(ident_val), .REVISION_CODE(rev_val))
	timing_bank_props_inst (.clk(clk), .nrst(nrst), .req(hb.req),
		.wr(hb.wr), .addr(hb.addr), .wdata(hb.wdata), .rdata(hb.rdata),
		.ack(hb.ack), .irq_request_output(hb.irq_request_output));
	////////////////////////////////////////////////////////////////////////
	task end_sim;
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task guard(inout int n);
		n++;
		if (n > 100) begin
			mismatches++;
			end_sim();
		end
	endtask : guard
	// Handshakes sampled at negedge so the combinational readies are settled
	task axi_wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(negedge clk);
		while (!(awready && wready)) begin
			guard(n);
			@(negedge clk);
		end
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(negedge clk);
		while (!bvalid) begin
			guard(n);
			@(negedge clk);
		end
		@(posedge clk);
		bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [31:0] a, output logic [31:0] d);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge clk);
		while (!arready) begin
			guard(n);
			@(negedge clk);
		end
		@(posedge clk);
		arvalid <= 1'b0;
		@(negedge clk);
		while (!rvalid) begin
			guard(n);
			@(negedge clk);
		end
		// Taken at the accepting edge; rready stays high between reads
		@(posedge clk);
		d = rdata;
	endtask : axi_rd
	// One host port access; status polls do not touch the host port
	task bank(input logic w, input logic [8:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] s;
		int n;
		n = 0;
		axi_wr(32'h0, {w, 7'h00, d, 7'h00, a});
		check({30'h0, bresp}, 32'h0);
		s = 32'h1;
		while (s[0] !== 1'b0) begin
			guard(n);
			axi_rd(32'h4, s);
		end
		check({30'h0, rresp}, 32'h0);
		q = s[15:8];
	endtask : bank
	task wr8(input logic [8:0] a, input logic [7:0] d);
		logic [7:0] q;
		bank(1'b1, a, d, q);
	endtask : wr8
	task rd_chk(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bank(1'b0, a, 8'h00, q);
		check({24'h0, q}, {24'h0, exp});
	endtask : rd_chk
	task irq_chk(input logic e);
		logic [31:0] s;
		axi_rd(32'h4, s);
		check({31'h0, s[1]}, {31'h0, e});
		check({31'h0, irq_level}, {31'h0, e});
	endtask : irq_chk
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (10000) @(posedge clk);
		rd_chk(9'h043, 8'h00);
		rd_chk(9'h045, 8'h00);
		rd_chk(9'h001, ident_val[15:8]);
		wr8(9'h000, 8'hFF);
		rd_chk(9'h000, ident_val[7:0]);
		rd_chk(9'h002, rev_val);
		wr8(9'h045, 8'h5F);
		rd_chk(9'h045, 8'h5F);
		wr8(9'h003, 8'h04);
		rd_chk(9'h003, 8'h04);
		foreach (far[i]) begin
			wr8(far[i], 8'h00);
			rd_chk(far[i], 8'h00);
		end
		rd_chk(9'h004, 8'h00);
		valid_lvl <= 4'hA;
		rd_chk(9'h00E, 8'h0A);
		valid_lvl <= 4'h5;
		rd_chk(9'h00E, 8'h05);
		rd_chk(9'h009, 8'h58);
		act <= 4'h1;
		rd_chk(9'h005, 8'h01);
		wr8(9'h005, 8'h00);
		rd_chk(9'h005, 8'h01);
		irq_chk(1'b0);
		wr8(9'h043, 8'h01);
		irq_chk(1'b1);
		wr8(9'h005, 8'h01);
		rd_chk(9'h005, 8'h00);
		irq_chk(1'b0);
		act <= 4'h0;
		rd_chk(9'h005, 8'h01);
		sync <= 4'h2;
		rd_chk(9'h017, 8'h02);
		wr8(9'h017, 8'h02);
		meas <= 19'h45678;
		phase <= 16'hBEEF;
		rd_chk(9'h00C, 8'h78);
		meas <= 19'h1ABCD;
		rd_chk(9'h007, 8'h04);
		rd_chk(9'h00D, 8'h56);
		rd_chk(9'h00D, 8'hAB);
		rd_chk(9'h000, ident_val[7:0]);
		rd_chk(9'h017, 8'h20);
		wr8(9'h017, 8'h20);
		rd_chk(9'h077, 8'hEF);
		rd_chk(9'h078, 8'hBE);
		wr8(9'h03C, 8'h34);
		check({16'h0, mclk}, 32'h0);
		wr8(9'h03D, 8'h12);
		check({16'h0, mclk}, 32'h1234);
		wr8(9'h047, 8'h12);
		wr8(9'h046, 8'h34);
		check({17'h0, divn}, 32'h1234);
		wr8(9'h046, 8'h78);
		rd_chk(9'h043, 8'h01);
		check({17'h0, divn}, 32'h1234);
		rd_chk(9'h017, 8'h20);
		wr8(9'h017, 8'h20);
		wr8(9'h032, 8'h80);
		check({31'h0, soft_reset}, 32'h1);
		check({16'h0, mclk}, 32'h0);
		rd_chk(9'h043, 8'h00);
		rd_chk(9'h032, 8'h80);
		rd_chk(9'h037, 8'h05);
		wr8(9'h032, 8'h00);
		check({31'h0, soft_reset}, 32'h0);
		end_sim();
	end
endmodule : tb_top
